//--- hw/wdr_pkg.sv
`default_nettype none
// ==========================================================
// Watchdog constants
package wdr_pkg;
   // Timeout period: 256*256*16 system clocks
   localparam int unsigned WDR_TIMEOUT_CYCLES = 256 * 256 * 16;
   localparam int unsigned WDR_CNT_W = 20;
   // Special register address that clears the watchdog
   localparam int unsigned WDR_ADDR_W = 5;
   localparam logic [4:0] WDR_ROM_DATA_HIGH_NIBBLE_ADDR = 5'h1d;
   // Reset length of the overflow reset pulse, in clocks
   localparam int unsigned WDR_RST_PULSE_CYCLES = 4;
   localparam int unsigned WDR_PULSE_W = 3;
   // Counter state encoding
   typedef enum logic [1:0]
   {
      WDR_ST_OFF = 2'b00,
      WDR_ST_RUN = 2'b01,
      WDR_ST_FIRE = 2'b10
   } wdr_state_t;
endpackage
`default_nettype wire

//--- hw/wdr_watchdog_reset_timer.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Overview of operation
// [R1] Counter returns to zero on wake-up, any system reset, or software clear.
// [R2] Timeout after 256*256*16 system clocks since last clear.
// [R3] Any write to register 1dh clears the watchdog and restarts the period.
// [R4] Software must clear before timeout while the watchdog is enabled.
// [R5] Overflow asserts a whole-system reset request.
// [R6] Executing halt clears the counter.
// [R7] Watchdog exists and acts only when the build option enables it.
// [R8] Option off: counter held at zero, overflow reset never asserted.
module wdr_watchdog_reset_timer
#(
   parameter bit P_ENABLE = 1'b1,
   parameter int unsigned P_TIMEOUT_CYCLES = wdr_pkg::WDR_TIMEOUT_CYCLES
)
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // Special register write port
   input wire logic i_reg_wr,
   input wire logic [wdr_pkg::WDR_ADDR_W-1:0] i_reg_addr,
   // Processor events
   input wire logic i_halt_exec,
   input wire logic i_wakeup,
   // Overflow reset and observation
   output logic o_wdt_reset,
   output logic [wdr_pkg::WDR_CNT_W-1:0] o_count
);
   import wdr_pkg::*;

   localparam logic [WDR_CNT_W-1:0] LAST_CNT = WDR_CNT_W'(P_TIMEOUT_CYCLES - 1);
   localparam logic [WDR_PULSE_W-1:0] PULSE_LAST = WDR_PULSE_W'(WDR_RST_PULSE_CYCLES - 1);

   // ==========================================================
   // Clear decode
   logic clear_req;
   assign clear_req = (i_reg_wr && (i_reg_addr == WDR_ROM_DATA_HIGH_NIBBLE_ADDR)) // [R3]
                      || i_halt_exec // [R6]
                      || i_wakeup; // [R1]

   // ==========================================================
   // State, counter and pulse length
   wdr_state_t state_q;
   logic [WDR_CNT_W-1:0] cnt_q;
   logic [WDR_PULSE_W-1:0] pulse_q;

   // Sequencing of run and fire phases
   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         state_q <= WDR_ST_OFF; // [R1]
      end
      else
      begin
         case (state_q)
            WDR_ST_OFF:
            begin
               if (P_ENABLE)
               begin
                  state_q <= WDR_ST_RUN; // [R7]
               end
            end
            WDR_ST_RUN:
            begin
               if (!clear_req && cnt_q == LAST_CNT)
               begin
                  state_q <= WDR_ST_FIRE; // [R2]
               end
            end
            WDR_ST_FIRE:
            begin
               if (pulse_q == PULSE_LAST)
               begin
                  state_q <= WDR_ST_RUN;
               end
            end
            default:
            begin
               state_q <= WDR_ST_OFF;
            end
         endcase
      end
   end

   // Timeout counter
   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         cnt_q <= '0; // [R1]
      end
      else if (!P_ENABLE || state_q != WDR_ST_RUN || clear_req || cnt_q == LAST_CNT)
      begin
         // Wrap to zero at terminal count as the fire phase starts
         cnt_q <= '0; // [R1] [R2] [R3] [R6] [R8]
      end
      else
      begin
         cnt_q <= cnt_q + 1'b1; // [R2]
      end
   end

   // Length of the overflow reset pulse
   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         pulse_q <= '0;
      end
      else if (state_q == WDR_ST_FIRE)
      begin
         pulse_q <= pulse_q + 1'b1;
      end
      else
      begin
         pulse_q <= '0;
      end
   end

   // Registered outputs
   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_wdt_reset <= 1'b0;
         o_count <= '0;
      end
      else
      begin
         o_wdt_reset <= P_ENABLE && (state_q == WDR_ST_FIRE); // [R5] [R8]
         o_count <= cnt_q;
      end
   end

   // ==========================================================
   // Checks: clearing
   // Clear request seen on one edge
   sequence s_clear;
      clear_req;
   endsequence

   // Counter at zero on the following edge
   sequence s_zeroed;
      ##1 cnt_q == '0;
   endsequence

   // Any clear source zeroes the counter
   a_clear_zeroes: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R1]
      s_clear |-> s_zeroed) else $error("counter not zeroed by clear");

   // Write to the data-high register clears
   a_wr_clears: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R3]
      (i_reg_wr && i_reg_addr == WDR_ROM_DATA_HIGH_NIBBLE_ADDR) |=> cnt_q == '0)
      else $error("register write did not clear");

   // Halt clears with no overflow pending
   a_halt_clears: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R6]
      i_halt_exec |=> !o_wdt_reset ##0 cnt_q == '0) else $error("halt did not clear");

   // Wake-up from halt clears
   a_wake_clears: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R1]
      i_wakeup |=> cnt_q == '0) else $error("wake-up did not clear");

   // ==========================================================
   // Checks: timeout
   // Terminal count reached with no clear pending
   sequence s_terminal;
      state_q == WDR_ST_RUN && cnt_q == LAST_CNT && !clear_req;
   endsequence

   // Counter advances by one while running
   a_count_steps: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R2]
      (state_q == WDR_ST_RUN && !clear_req && cnt_q != LAST_CNT)
      |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("counter did not advance");

   // Timeout leads to the overflow pulse two edges later
   a_timeout_fires: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R2]
      s_terminal |=> ##1 o_wdt_reset) else $error("no reset at timeout");

   // Terminal count wraps the counter to zero
   a_terminal_wraps: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R2]
      s_terminal |=> cnt_q == '0) else $error("counter did not wrap at timeout");

   // Counter never passes the terminal value
   a_count_bounded: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R2]
      cnt_q <= LAST_CNT) else $error("counter beyond terminal value");

   // No overflow pulse before the full period
   a_no_early_fire: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R2]
      $rose(o_wdt_reset) |-> $past(cnt_q, 2) == LAST_CNT) else $error("early reset");

   // ==========================================================
   // Checks: overflow pulse
   // Pulse stands four cycles, then drops
   sequence s_pulse;
      o_wdt_reset [*4] ##1 !o_wdt_reset;
   endsequence

   // Last cycle of the fire phase
   sequence s_fire_end;
      state_q == WDR_ST_FIRE && pulse_q == PULSE_LAST;
   endsequence

   // Overflow reset lasts the pulse length
   a_pulse_length: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R5]
      $rose(o_wdt_reset) |-> s_pulse) else $error("reset pulse length wrong");

   // Pulse counter stays within the pulse length
   a_pulse_bounded: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R5]
      state_q == WDR_ST_FIRE |-> pulse_q <= PULSE_LAST) else $error("pulse counter overrun");

   // Fire phase returns to counting from zero
   a_fire_restarts: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R5]
      s_fire_end |=> state_q == WDR_ST_RUN && cnt_q == '0) else $error("no restart after pulse");

   // ==========================================================
   // Checks: build option and system reset
   // Disabled build never counts nor fires
   a_disabled_quiet: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R7] [R8]
      !P_ENABLE |-> cnt_q == '0 && !o_wdt_reset) else $error("disabled watchdog active");

   // Enabled build starts running after reset
   a_enabled_runs: assert property (@(posedge i_core_clk) disable iff (i_reset) // [R7]
      (P_ENABLE && state_q == WDR_ST_OFF) |=> state_q == WDR_ST_RUN)
      else $error("enabled watchdog idle");

   // Reset leaves counter and pulse cleared
   a_reset_zero: assert property (@(posedge i_core_clk) // [R1]
      $fell(i_reset) |-> cnt_q == '0 && !o_wdt_reset) else $error("reset did not clear");

endmodule // wdr_watchdog_reset_timer
`default_nettype wire

//--- tb/tb_wdr_watchdog_reset_timer.sv
`timescale 1ns/10ps
`default_nettype none
module tb_wdr_watchdog_reset_timer;
   import wdr_pkg::*;
   localparam int T = 16;
   logic i_core_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_reg_wr = 1'b0;
   logic [4:0] i_reg_addr = 5'h00;
   logic i_halt_exec = 1'b0;
   logic i_wakeup = 1'b0;
   logic rst_on, rst_off;
   logic [19:0] cnt_on, cnt_off;
   int errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int n;
   logic [31:0] seed = 32'h958ae09e;
   // Enabled and disabled builds share stimulus
   wdr_watchdog_reset_timer #(.P_ENABLE(1'b1), .P_TIMEOUT_CYCLES(T)) u_wdr_watchdog_reset_timer
      (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
      .i_halt_exec(i_halt_exec), .i_wakeup(i_wakeup), .o_wdt_reset(rst_on), .o_count(cnt_on));
   wdr_watchdog_reset_timer #(.P_ENABLE(1'b0), .P_TIMEOUT_CYCLES(T)) u_wdr_watchdog_reset_timer_off
      (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
      .i_halt_exec(i_halt_exec), .i_wakeup(i_wakeup), .o_wdt_reset(rst_off), .o_count(cnt_off));
   // Clock, 50 ns period
   initial
   begin
      forever #25 i_core_clk = ~i_core_clk;
   end
   // Hang guard
   always @(posedge i_core_clk)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         errors++;
         final_report();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Count shown on o_count so many edges after the zeroing edge
   function automatic logic [31:0] exp_count(input int edges);
      return 32'((edges - 1) % T);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One-cycle event: 0 write 1dh, 1 halt, 2 wakeup, 3 other address
   task automatic pulse(input int k);
      @(negedge i_core_clk);
      i_reg_wr = (k == 0 || k == 3);
      i_reg_addr = (k == 3) ? ((seed[4:0] == 5'h1d) ? 5'h1e : seed[4:0]) : 5'h1d;
      i_halt_exec = (k == 1);
      i_wakeup = (k == 2);
      @(negedge i_core_clk);
      {i_reg_wr, i_halt_exec, i_wakeup} = 3'h0;
   endtask
   task automatic final_report();
      $display("errors %0d of %0d compares", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(negedge i_core_clk);
      i_reset = 1'b0;
      repeat (3) @(negedge i_core_clk);
      // Random clears and foreign writes
      repeat (200)
      begin
         seed = lfsr(seed);
         pulse(seed[9:8] == 2'h3 ? 0 : seed[9:8]);
         @(negedge i_core_clk);
         check(cnt_on, 0);
         if (seed[9:8] == 2'h3)
         begin
            pulse(3);
            @(negedge i_core_clk);
            check(cnt_on, exp_count(4));
         end
         check(rst_on, 0);
         check({rst_off, cnt_off}, 0);
      end
      $display("test clears done");
      // Clear in the terminal cycle wins over the timeout
      pulse(0);
      repeat (T - 2) @(negedge i_core_clk);
      pulse(0);
      @(negedge i_core_clk);
      check(rst_on, 0);
      check(cnt_on, exp_count(1));
      $display("test terminal clear done");
      // Starve the counter until it fires
      pulse(0);
      n = 0;
      while (rst_on !== 1'b1 && n < 4 * T)
      begin
         @(negedge i_core_clk);
         n++;
         check(cnt_on, exp_count(n));
      end
      check(n, T + 1);
      n = 0;
      while (rst_on === 1'b1 && n < 10)
      begin
         @(negedge i_core_clk);
         check({rst_off, cnt_off}, 0);
         n++;
      end
      check(n, WDR_RST_PULSE_CYCLES);
      @(negedge i_core_clk);
      check(cnt_on, exp_count(2));
      $display("test overflow done");
      // Reset in mid-count zeroes the counter, which then restarts
      @(negedge i_core_clk);
      i_reset = 1'b1;
      @(negedge i_core_clk);
      check({rst_on, cnt_on}, 0);
      i_reset = 1'b0;
      repeat (3) @(negedge i_core_clk);
      check(cnt_on, exp_count(2));
      $display("test reset done");
      final_report();
   end
endmodule // tb_wdr_watchdog_reset_timer
`default_nettype wire
